// [verilog/cmap_path.sv]
// Core memory access path: routing, unaligned split, store buffer, monitor
// Notes on behaviour
// - Code region: fetches go on instr_code_bus, data on data_code_bus.
// - SRAM, peripheral, external RAM and device regions use the system bus.
// - Aligned data accesses in bit-band alias areas are alias accesses; fetches are not.
// - Fetches from private and vendor system regions always fault.
// - Core wins arbitration over debug; a debug transfer under way delays the core.
// - Unaligned singles split so every bus transfer is aligned.
// - Only word and halfword may be unaligned; unaligned doubleword faults.
// - Odd half: two bytes; half-aligned word: two halves; odd word: byte, half, byte.
// - Code-space data pieces wrap: 0x1FFFFFFF then 0x00000000.
// - System access past 0xDFFFFFFF continues at 0xE0000000, no wrap.
// - System halfword at 0xFFFFFFFF continues at address zero.
// - Unaligned accesses to the private region are refused.
// - Unaligned pieces reaching an alias area are plain byte or halfword accesses, no alias.
// - Patch unit remaps aligned literal loads only.
// - One-entry store buffer; further accesses stall until it drains.
// - A store is buffered only when its data phase is waited.
// - Barriers complete only with the store buffer empty.
// - Interrupt during barrier wait retires barrier; entry waits for drain.
// - Exclusive monitor holds no address; granule is whole space.
// - Exclusive accesses to bit-band areas are refused.
// - Private region split into internal and external private bus.
`timescale 1ns/1ps
`include "cmap_map.svh"
module cmap_path import cmap_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Core request
  input wire logic core_req,
  input wire logic [31:0] core_addr,
  input wire logic [1:0] core_size,
  input wire logic core_write,
  input wire logic core_fetch,
  input wire logic core_excl,
  input wire logic core_bufable,
  input wire logic core_literal,
  input wire logic [63:0] core_wdata,
  output logic core_done,
  output logic core_fault,
  output logic core_excl_fail,
  output logic [63:0] core_rdata,
  // Patch unit comparator
  input wire logic patch_hit,
  input wire logic [31:0] patch_addr,
  // Debug request
  input wire logic dbg_req,
  input wire logic [31:0] dbg_addr,
  input wire logic [1:0] dbg_size,
  input wire logic dbg_write,
  input wire logic [31:0] dbg_wdata,
  output logic dbg_done,
  output logic dbg_fault,
  output logic [31:0] dbg_rdata,
  // Barrier and exception entry
  input wire logic bar_req,
  input wire logic irq_req,
  output logic bar_done,
  output logic bar_retire,
  output logic irq_ack,
  // Bus side
  output logic ic_valid,
  output logic dc_valid,
  output logic sys_valid,
  output logic ppbi_valid,
  output logic ppbe_valid,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic bus_write,
  output logic [31:0] bus_wdata,
  output logic bus_alias,
  input wire logic bus_ready,
  input wire logic [31:0] bus_rdata
);
  // ----------------------------------------
  // Request selection
  // ----------------------------------------
  cmap_state_t state_ff;
  logic take, from_core;
  logic [31:0] r_addr;
  logic [1:0] r_size;
  logic r_write, r_fetch, r_excl;
  logic [63:0] r_wdata;
  logic unal, fault_c, skip_c;
  cmap_region_t r_reg;
  logic r_ext, r_bb, r_alias;
  cmap_tgt_t r_tgt;
  logic resv_ff;

  assign take = (state_ff == ST_IDLE) && (core_req || dbg_req);
  assign from_core = core_req;

  always_comb begin
    r_addr = core_req ? core_addr : dbg_addr;
    r_size = core_req ? core_size : dbg_size;
    r_write = core_req ? core_write : dbg_write;
    r_fetch = core_req && core_fetch;
    r_excl = core_req && core_excl;
    r_wdata = core_req ? core_wdata : {32'h0, dbg_wdata};
    // Remap only when the literal load is aligned
    if (core_req && core_literal && patch_hit && !core_write &&
        (core_addr[1:0] == 2'h0)) begin
      r_addr = patch_addr;
    end
  end

  cmap_region u_dec (
    .addr(r_addr),
    .region(r_reg),
    .priv_ext(r_ext),
    .in_bb(r_bb),
    .in_alias(r_alias)
  );

  always_comb begin
    case (r_size)
      `CMAP_SZ_BYTE: unal = 1'b0;
      `CMAP_SZ_HALF: unal = r_addr[0];
      default: unal = (r_addr[1:0] != 2'h0);
    endcase
    fault_c = ((r_size == `CMAP_SZ_DBL) && unal) ||
              (r_fetch && ((r_reg == RG_PRIV) || (r_reg == RG_SYSV))) ||
              (unal && (r_reg == RG_PRIV)) ||
              (r_excl && (r_bb || r_alias));
    // Store-exclusive with no reservation never reaches the bus
    skip_c = r_excl && r_write && !resv_ff;
    if (r_reg == RG_CODE) begin
      r_tgt = r_fetch ? TG_IC : TG_DC;
    end else if (r_reg == RG_PRIV) begin
      r_tgt = r_ext ? TG_PPBE : TG_PPBI;
    end else begin
      r_tgt = TG_SYS;
    end
  end

  // ----------------------------------------
  // Piece sequencing
  // ----------------------------------------
  logic go;
  logic [31:0] base_ff;
  logic [1:0] size_ff, idx_ff, n_idx;
  logic wrap_ff, write_ff, core_own_ff, bufable_ff, first_ff, excl_ff;
  cmap_tgt_t tgt_ff;
  logic [63:0] wdata_ff, acc_ff, nxt_acc;
  logic [31:0] s_base, n_paddr, nxt_wd, paddr_ff, wd_src;
  logic [1:0] s_size, n_psize, psize_ff;
  logic [2:0] n_poff, poff_ff;
  logic s_wrap, n_plast, plast_ff;
  logic [1:0] lane_m1;
  logic adv, fin, to_buf;

  assign go = take && !fault_c && !skip_c;
  assign s_base = go ? r_addr : base_ff;
  assign s_size = go ? r_size : size_ff;
  assign s_wrap = go ? (r_tgt == TG_DC) : wrap_ff;
  assign n_idx = go ? 2'h0 : 2'(idx_ff + 2'h1);

  cmap_split u_split (
    .base(s_base),
    .size(s_size),
    .wrap(s_wrap),
    .idx(n_idx),
    .paddr(n_paddr),
    .psize(n_psize),
    .poff(n_poff),
    .plast(n_plast)
  );

  assign adv = (state_ff == ST_XFER) && bus_ready;
  assign fin = adv && plast_ff;
  // Buffer only a waited single-piece bufferable core store
  assign to_buf = (state_ff == ST_XFER) && !bus_ready && first_ff && plast_ff &&
                  write_ff && bufable_ff && core_own_ff &&
                  ((tgt_ff == TG_DC) || (tgt_ff == TG_SYS));

  always_comb begin
    wd_src = 32'h0;
    nxt_wd = 32'h0;
    for (int j = 0; j < 4; j++) begin
      wd_src[j*8 +: 8] = go ? r_wdata[(32'(n_poff) + j)*8 +: 8] :
                              wdata_ff[(32'(n_poff) + j)*8 +: 8];
    end
    // Place piece bytes at their own lanes: transfer is aligned
    for (int j = 0; j < 4; j++) begin
      if (j >= 32'(n_paddr[1:0])) begin
        nxt_wd[j*8 +: 8] = wd_src[(j - 32'(n_paddr[1:0]))*8 +: 8];
      end
    end
  end

  always_comb begin
    lane_m1 = (psize_ff == `CMAP_SZ_WORD) ? 2'h3 :
              ((psize_ff == `CMAP_SZ_HALF) ? 2'h1 : 2'h0);
    nxt_acc = acc_ff;
    for (int j = 0; j < 4; j++) begin
      if (j <= 32'(lane_m1)) begin
        nxt_acc[(32'(poff_ff) + j)*8 +: 8] = bus_rdata[(32'(paddr_ff[1:0]) + j)*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: if (go) state_ff <= ST_XFER;
        ST_XFER: begin
          if (fin) state_ff <= ST_IDLE;
          else if (to_buf) state_ff <= ST_BUFD;
        end
        ST_BUFD: if (bus_ready) state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      base_ff <= 32'h0;
      size_ff <= 2'h0;
      wrap_ff <= 1'b0;
      write_ff <= 1'b0;
      core_own_ff <= 1'b0;
      bufable_ff <= 1'b0;
      excl_ff <= 1'b0;
      tgt_ff <= TG_SYS;
      wdata_ff <= 64'h0;
      bus_alias <= 1'b0;
    end else if (go) begin
      base_ff <= r_addr;
      size_ff <= r_size;
      wrap_ff <= (r_tgt == TG_DC);
      write_ff <= r_write;
      core_own_ff <= from_core;
      bufable_ff <= core_bufable;
      excl_ff <= r_excl;
      tgt_ff <= r_tgt;
      wdata_ff <= r_wdata;
      // Unaligned pieces never alias, even if they land in an alias area
      bus_alias <= !r_fetch && r_alias && !unal;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      paddr_ff <= 32'h0;
      psize_ff <= 2'h0;
      poff_ff <= 3'h0;
      plast_ff <= 1'b0;
      idx_ff <= 2'h0;
      bus_wdata <= 32'h0;
    end else if (go || (adv && !plast_ff)) begin
      paddr_ff <= n_paddr;
      psize_ff <= n_psize;
      poff_ff <= n_poff;
      plast_ff <= n_plast;
      idx_ff <= n_idx;
      bus_wdata <= nxt_wd;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      first_ff <= 1'b0;
      acc_ff <= 64'h0;
    end else if (go) begin
      first_ff <= 1'b1;
      acc_ff <= 64'h0;
    end else if (state_ff == ST_XFER) begin
      first_ff <= 1'b0;
      if (bus_ready) acc_ff <= nxt_acc;
    end
  end

  // ----------------------------------------
  // Answers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_done <= 1'b0;
      core_fault <= 1'b0;
      core_excl_fail <= 1'b0;
      core_rdata <= 64'h0;
      dbg_done <= 1'b0;
      dbg_fault <= 1'b0;
      dbg_rdata <= 32'h0;
    end else begin
      core_done <= (take && from_core && (fault_c || skip_c)) ||
                   ((fin || to_buf) && core_own_ff);
      core_fault <= take && from_core && fault_c;
      core_excl_fail <= take && from_core && !fault_c && skip_c;
      dbg_done <= (take && !from_core && fault_c) || (fin && !core_own_ff);
      dbg_fault <= take && !from_core && fault_c;
      if (fin && core_own_ff) core_rdata <= write_ff ? 64'h0 : nxt_acc;
      if (fin && !core_own_ff) dbg_rdata <= write_ff ? 32'h0 : nxt_acc[31:0];
    end
  end

  // ----------------------------------------
  // Exclusive monitor
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      resv_ff <= 1'b0;
    end else if (take && from_core && r_excl && !fault_c) begin
      resv_ff <= !r_write;
    end else if (irq_ack) begin
      resv_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Barriers and bus drive
  // ----------------------------------------
  logic buf_busy, act;
  assign buf_busy = (state_ff == ST_BUFD);
  assign bar_done = bar_req && !buf_busy;
  assign bar_retire = bar_req && irq_req && buf_busy;
  assign irq_ack = irq_req && !buf_busy;
  assign act = (state_ff == ST_XFER) || buf_busy;
  assign ic_valid = act && (tgt_ff == TG_IC);
  assign dc_valid = act && (tgt_ff == TG_DC);
  assign sys_valid = act && (tgt_ff == TG_SYS);
  assign ppbi_valid = act && (tgt_ff == TG_PPBI);
  assign ppbe_valid = act && (tgt_ff == TG_PPBE);
  assign bus_addr = paddr_ff;
  assign bus_size = psize_ff;
  assign bus_write = write_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  code_fetch_route_a: assert property (@(posedge mclk) disable iff (!resetn)
    (go && r_fetch && (r_reg == RG_CODE)) |=> ic_valid && !dc_valid)
    else $error("code fetch not on instr code bus");
  code_data_route_a: assert property (@(posedge mclk) disable iff (!resetn)
    (go && !r_fetch && (r_reg == RG_CODE)) |=> dc_valid && !ic_valid)
    else $error("code data not on data code bus");
  sys_route_a: assert property (@(posedge mclk) disable iff (!resetn)
    (go && (r_reg inside {RG_SRAM, RG_PERI, RG_XRAM, RG_XDEV})) |=> sys_valid)
    else $error("region not routed to system bus");
  no_exec_fetch_a: assert property (@(posedge mclk) disable iff (!resetn)
    (take && r_fetch && (r_addr >= `CMAP_PRIV_BASE)) |=> core_fault && !act)
    else $error("fetch from no-execute region allowed");
  core_first_a: assert property (@(posedge mclk) disable iff (!resetn)
    (take && core_req && dbg_req) |=> !dbg_done && !dbg_fault)
    else $error("debug served ahead of core");
  aligned_out_a: assert property (@(posedge mclk) disable iff (!resetn)
    act |-> !((bus_size == `CMAP_SZ_WORD) && (bus_addr[1:0] != 2'h0)) &&
            !((bus_size == `CMAP_SZ_HALF) && bus_addr[0]))
    else $error("unaligned transfer left the core");
  dbl_fault_a: assert property (@(posedge mclk) disable iff (!resetn)
    (take && (r_size == `CMAP_SZ_DBL) && (r_addr[1:0] != 2'h0)) |=> !act)
    else $error("unaligned doubleword performed");
  odd_word_a: assert property (@(posedge mclk) disable iff (!resetn)
    (go && (r_size == `CMAP_SZ_WORD) && r_addr[0]) ##1 bus_ready[*3] |->
    (bus_size == `CMAP_SZ_BYTE) && ($past(bus_size) == `CMAP_SZ_HALF))
    else $error("odd word not split byte half byte");
  code_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    (dc_valid && bus_ready && !plast_ff && (bus_addr == `CMAP_CODE_MASK)) |=>
    (bus_addr == 32'h0))
    else $error("code data piece did not wrap");
  buf_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (buf_busy && !bus_ready) |=> buf_busy && $stable(bus_addr) && !core_done)
    else $error("store buffer entry lost or overtaken");
  bar_drain_a: assert property (@(posedge mclk) disable iff (!resetn)
    bar_done |-> (state_ff != ST_BUFD))
    else $error("barrier completed with store buffered");
  excl_fail_a: assert property (@(posedge mclk) disable iff (!resetn)
    (take && core_req && core_excl && core_write && !resv_ff && !fault_c) |=>
    core_excl_fail && core_done && !act)
    else $error("exclusive store without reservation reached bus");
endmodule

// [verilog/cmap_map.svh]
// Address map, size codes and bounds of the core memory access path
`ifndef CMAP_MAP_SVH
`define CMAP_MAP_SVH
// ----------------------------------------
// Region bases
// ----------------------------------------
`define CMAP_SRAM_BASE 32'h2000_0000
`define CMAP_PERI_BASE 32'h4000_0000
`define CMAP_XRAM_BASE 32'h6000_0000
`define CMAP_XDEV_BASE 32'hA000_0000
`define CMAP_PRIV_BASE 32'hE000_0000
`define CMAP_PPBX_BASE 32'hE004_0000
`define CMAP_SYSV_BASE 32'hE010_0000
`define CMAP_CODE_MASK 32'h1FFF_FFFF
// ----------------------------------------
// Bit-band areas
// ----------------------------------------
`define CMAP_BB_SPAN 32'h0010_0000
`define CMAP_SRAM_ALIAS 32'h2200_0000
`define CMAP_PERI_ALIAS 32'h4200_0000
`define CMAP_ALIAS_SPAN 32'h0200_0000
// ----------------------------------------
// Transfer size codes
// ----------------------------------------
`define CMAP_SZ_BYTE 2'h0
`define CMAP_SZ_HALF 2'h1
`define CMAP_SZ_WORD 2'h2
`define CMAP_SZ_DBL 2'h3
`endif

// [verilog/cmap_pkg.sv]
// Types shared by the core memory access path modules
package cmap_pkg;
  typedef enum logic [2:0] {RG_CODE, RG_SRAM, RG_PERI, RG_XRAM, RG_XDEV, RG_PRIV, RG_SYSV}
    cmap_region_t;
  typedef enum logic [2:0] {TG_IC, TG_DC, TG_SYS, TG_PPBI, TG_PPBE} cmap_tgt_t;
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_BUFD} cmap_state_t;
endpackage

// [verilog/cmap_region.sv]
// Address region decoder
`timescale 1ns/1ps
`include "cmap_map.svh"
module cmap_region import cmap_pkg::*; (
  // Address in
  input wire logic [31:0] addr,
  // Decode out
  output cmap_region_t region,
  output logic priv_ext,
  output logic in_bb,
  output logic in_alias
);
  always_comb begin
    if (addr < `CMAP_SRAM_BASE) region = RG_CODE;
    else if (addr < `CMAP_PERI_BASE) region = RG_SRAM;
    else if (addr < `CMAP_XRAM_BASE) region = RG_PERI;
    else if (addr < `CMAP_XDEV_BASE) region = RG_XRAM;
    else if (addr < `CMAP_PRIV_BASE) region = RG_XDEV;
    else if (addr < `CMAP_SYSV_BASE) region = RG_PRIV;
    else region = RG_SYSV;
  end
  assign priv_ext = (addr >= `CMAP_PPBX_BASE);
  assign in_bb = ((addr - `CMAP_SRAM_BASE) < `CMAP_BB_SPAN) ||
                 ((addr - `CMAP_PERI_BASE) < `CMAP_BB_SPAN);
  assign in_alias = ((addr - `CMAP_SRAM_ALIAS) < `CMAP_ALIAS_SPAN) ||
                    ((addr - `CMAP_PERI_ALIAS) < `CMAP_ALIAS_SPAN);
endmodule

// [verilog/cmap_split.sv]
// Splits one access into aligned pieces, one piece per index
`timescale 1ns/1ps
`include "cmap_map.svh"
module cmap_split import cmap_pkg::*; (
  // Access
  input wire logic [31:0] base,
  input wire logic [1:0] size,
  input wire logic wrap,
  input wire logic [1:0] idx,
  // Piece
  output logic [31:0] paddr,
  output logic [1:0] psize,
  output logic [2:0] poff,
  output logic plast
);
  logic [31:0] sum;
  always_comb begin
    psize = `CMAP_SZ_BYTE;
    poff = 3'h0;
    plast = 1'b1;
    case (size)
      `CMAP_SZ_BYTE: begin
        psize = `CMAP_SZ_BYTE;
      end
      `CMAP_SZ_HALF: begin
        if (base[0]) begin
          poff = {2'h0, idx[0]};
          plast = idx[0];
        end else begin
          psize = `CMAP_SZ_HALF;
        end
      end
      `CMAP_SZ_WORD: begin
        if (base[1:0] == 2'h0) begin
          psize = `CMAP_SZ_WORD;
        end else if (base[1:0] == 2'h2) begin
          psize = `CMAP_SZ_HALF;
          poff = idx[0] ? 3'h2 : 3'h0;
          plast = idx[0];
        end else begin
          case (idx)
            2'h0: begin
              plast = 1'b0;
            end
            2'h1: begin
              psize = `CMAP_SZ_HALF;
              poff = 3'h1;
              plast = 1'b0;
            end
            default: begin
              poff = 3'h3;
            end
          endcase
        end
      end
      default: begin
        psize = `CMAP_SZ_WORD;
        poff = idx[0] ? 3'h4 : 3'h0;
        plast = idx[0];
      end
    endcase
    sum = base + {29'h0, poff};
    // Code-space data pieces stay inside the code region
    paddr = wrap ? (sum & `CMAP_CODE_MASK) : sum;
  end
endmodule

// [verif/cmap_bus_model.sv]
// Bus fabric and slave model answering the access path's transfers
`timescale 1ns/1ps
module cmap_bus_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Transfer from the access path
  input wire logic any_valid,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0] waits,
  // Answer
  output logic bus_ready,
  output logic [31:0] bus_rdata
);
  logic [3:0] cnt_ff;
  logic [31:0] junk_ff;

  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h5A;
  endfunction

  // Wait states counted from the first cycle of each piece
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) cnt_ff <= 4'h0;
    else if (any_valid && !bus_ready) cnt_ff <= cnt_ff + 4'h1;
    else cnt_ff <= 4'h0;
  end

  // Read lines carry no stale value outside the answering cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) junk_ff <= 32'hA5A5_5A5A;
    else junk_ff <= ~junk_ff;
  end

  assign bus_ready = any_valid && (cnt_ff >= waits);
  assign bus_rdata = bus_ready ? {pat({bus_addr[31:2], 2'h3}), pat({bus_addr[31:2], 2'h2}),
    pat({bus_addr[31:2], 2'h1}), pat({bus_addr[31:2], 2'h0})} : junk_ff;
endmodule

// [verif/core_memory_access_path_tb.sv]
// Self-checking bench for the core memory access path
`timescale 1ns/1ps
module core_memory_access_path_tb import cmap_pkg::*; ;
  logic mclk, resetn, core_req, core_write, core_fetch, core_excl, core_bufable, core_literal;
  logic [31:0] core_addr, patch_addr, dbg_addr, dbg_wdata, bus_addr, bus_wdata, bus_rdata;
  logic [31:0] dbg_rdata;
  logic [1:0] core_size, dbg_size, bus_size;
  logic [63:0] core_wdata, core_rdata, got_rd;
  logic patch_hit, dbg_req, dbg_write, bar_req, irq_req, bus_ready, got_fault, got_xf, mon;
  logic core_done, core_fault, core_excl_fail, dbg_done, dbg_fault, bar_done, bar_retire;
  logic irq_ack, ic_valid, dc_valid, sys_valid, ppbi_valid, ppbe_valid, bus_write, bus_alias;
  logic [3:0] waits;
  logic [15:0] lfsr_val;
  int mismatches, checks_done, lat;
  logic [31:0] q_addr[$], q_wd[$], e_addr[$];
  logic [1:0] q_size[$], e_size[$];
  cmap_tgt_t q_tgt[$];
  logic q_alias[$];
  wire any_valid = ic_valid | dc_valid | sys_valid | ppbi_valid | ppbe_valid;
  localparam logic [31:0] RA [16] = '{32'h0000_1000, 32'h1FFF_FFFC, 32'h1FFF_FFFC,
    32'h2000_0000, 32'h5FFF_FFFC, 32'h9FFF_FFFC, 32'hDFFF_FFFC, 32'hE003_FFFC, 32'hE004_0000,
    32'hE00F_FFFC, 32'hE010_0000, 32'hE000_0000, 32'hE010_0000, 32'h2200_0000, 32'h2200_0000,
    32'h4200_0004};
  localparam logic RF [16] = '{1, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 1, 0};
  localparam logic [31:0] SA [12] = '{32'h2000_0001, 32'h2000_0002, 32'h2000_0001,
    32'h2000_0003, 32'h1FFF_FFFF, 32'hDFFF_FFFF, 32'hFFFF_FFFF, 32'h21FF_FFFF, 32'h2000_0004,
    32'h2000_0006, 32'hE000_0001, 32'hE000_0002};
  localparam logic [1:0] SS [12] = '{1, 2, 2, 2, 1, 1, 1, 1, 3, 3, 1, 2};

  cmap_path DUT (.*);
  cmap_bus_model SLV (.*);

  always #12.5 mclk = ~mclk;

  // ----------------------------------------
  // Piece monitor and helpers
  // ----------------------------------------
  always @(posedge mclk) begin
    if (any_valid && bus_ready) begin
      q_addr.push_back(bus_addr);
      q_size.push_back(bus_size);
      q_wd.push_back(bus_wdata);
      q_alias.push_back(bus_alias);
      q_tgt.push_back(ic_valid ? TG_IC : dc_valid ? TG_DC : sys_valid ? TG_SYS :
        ppbi_valid ? TG_PPBI : TG_PPBE);
    end
  end

  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h5A;
  endfunction

  function automatic logic alias_at(input logic [31:0] a);
    return a[31:25] == 7'h11 || a[31:25] == 7'h21;
  endfunction

  function automatic logic [15:0] rnd();
    lfsr_val = {lfsr_val[14:0], lfsr_val[15] ^ lfsr_val[13] ^ lfsr_val[12] ^ lfsr_val[10]};
    return lfsr_val;
  endfunction

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (exp !== got) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_on(input int w);
    int n;
    n = 0;
    while (n < 60 && (w == 0 ? core_done : w == 1 ? dbg_done : bar_done) !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
    end
    lat = n;
    if (n >= 60) begin
      chk("handshake wait", 1, 0);
      wrap_up();
    end
  endtask

  task automatic issue(input logic [31:0] a, input logic [1:0] s, input logic wr, fe, ex, bf, li);
    @(negedge mclk);
    core_addr = a;
    core_size = s;
    {core_write, core_fetch, core_excl, core_bufable, core_literal} = {wr, fe, ex, bf, li};
    core_wdata = {rnd(), rnd(), rnd(), rnd()};
    core_req = 1'b1;
    wait_on(0);
    got_fault = core_fault;
    got_xf = core_excl_fail;
    got_rd = core_rdata;
    @(negedge mclk);
    core_req = 1'b0;
  endtask

  // Reference model: expected pieces, routing, fault and read data
  task automatic settle(input logic [31:0] a, input logic [1:0] s, input logic wr, fe, ex, li,
    input logic [63:0] wd);
    logic [31:0] p, w;
    logic [63:0] rd, msk;
    logic mis, flt, xf, al, wrapc;
    cmap_tgt_t tg;
    int k, j, b, n;
    e_addr.delete();
    e_size.delete();
    mis = (s == 2'h3) ? (a[1:0] != 2'h0) : ((a & ((32'h1 << s) - 32'h1)) != 32'h0);
    flt = (s == 2'h3 && mis) || (fe && a >= 32'hE000_0000) || (mis && a[31:20] == 12'hE00)
      || (ex && (a[31:20] == 12'h200 || a[31:20] == 12'h400 || alias_at(a)));
    xf = ex && wr && !flt && !mon;
    if (ex && !flt) mon = !wr;
    p = (li && !wr && patch_hit && !mis) ? patch_addr : a;
    wrapc = p < 32'h2000_0000;
    tg = wrapc ? (fe ? TG_IC : TG_DC) : (p[31:20] == 12'hE00) ?
      (p[19:18] == 2'h0 ? TG_PPBI : TG_PPBE) : TG_SYS;
    al = !fe && !mis && alias_at(p);
    if (!flt && !xf) begin
      if (s == 2'h3) e_addr = '{p, p + 4};
      else if (!mis) e_addr = '{p};
      else if (s == 2'h1) e_addr = '{p, p + 1};
      else if (p[1:0] == 2'h2) e_addr = '{p, p + 2};
      else e_addr = '{p, p + 1, p + 3};
      if (s == 2'h3) e_size = '{2'h2, 2'h2};
      else if (!mis) e_size = '{s};
      else if (s == 2'h1) e_size = '{2'h0, 2'h0};
      else if (p[1:0] == 2'h2) e_size = '{2'h1, 2'h1};
      else e_size = '{2'h0, 2'h1, 2'h0};
    end
    n = 0;
    while (q_addr.size() < e_addr.size() && n < 60) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 60) begin
      chk("piece wait", 1, 0);
      wrap_up();
    end
    chk("fault", flt, got_fault);
    chk("excl fail", xf, got_xf);
    b = 0;
    rd = '0;
    foreach (e_addr[k]) begin
      if (wrapc) e_addr[k] = e_addr[k] & 32'h1FFF_FFFF;
      chk("piece addr", e_addr[k], q_addr.pop_front());
      chk("piece size", e_size[k], q_size.pop_front());
      chk("bus", tg, q_tgt.pop_front());
      chk("alias", al, q_alias.pop_front());
      w = q_wd.pop_front();
      for (j = 0; j < (1 << e_size[k]); j++) begin
        p = e_addr[k] + j;
        if (wr) chk("wdata", wd[8*b+:8], w[8*p[1:0]+:8]);
        rd[8*b+:8] = pat(p);
        b++;
      end
    end
    msk = (b >= 8) ? '1 : ((64'h1 << (8 * b)) - 64'h1);
    if (!wr && b > 0) chk("rdata", rd & msk, got_rd & msk);
  endtask

  task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic wr, fe, ex, bf, li);
    issue(a, s, wr, fe, ex, bf, li);
    settle(a, s, wr, fe, ex, li, core_wdata);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [63:0] wd;
    {mclk, resetn, core_req, core_write, core_fetch, core_excl, core_bufable} = '0;
    {core_literal, patch_hit, dbg_req, dbg_write, bar_req, irq_req, mon} = '0;
    {core_addr, core_size, core_wdata, patch_addr, dbg_addr, dbg_size, dbg_wdata} = '0;
    waits = 4'h0;
    lfsr_val = 16'h0043;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    foreach (RA[i]) acc(RA[i], 2'h2, 0, RF[i], 0, 0, 0);
    for (int w = 0; w < 2; w++) foreach (SA[i]) acc(SA[i], SS[i], w, 0, 0, 0, 0);
    acc(32'h2010_0000, 2'h2, 0, 0, 1, 0, 0);
    acc(32'h3000_0000, 2'h2, 1, 0, 1, 0, 0);
    acc(32'h3000_0000, 2'h2, 1, 0, 1, 0, 0);
    acc(32'h2000_0010, 2'h2, 0, 0, 1, 0, 0);
    acc(32'h4200_0000, 2'h2, 0, 0, 1, 0, 0);
    patch_hit = 1'b1;
    patch_addr = 32'h0000_2000;
    acc(32'h0000_0100, 2'h2, 0, 0, 0, 0, 1);
    acc(32'h0000_0101, 2'h2, 0, 0, 0, 0, 1);
    patch_hit = 1'b0;
    waits = 4'h3;
    issue(32'h2000_0200, 2'h2, 1, 0, 0, 1, 0);
    chk("bus busy after done", 1, sys_valid);
    chk("pieces before drain", 0, q_addr.size());
    chk("buffered done cycles", 2, lat);
    @(negedge mclk);
    bar_req = 1'b1;
    irq_req = 1'b1;
    #1;
    chk("barrier early", 0, bar_done);
    chk("barrier retire", 1, bar_retire);
    chk("irq ack early", 0, irq_ack);
    wait_on(2);
    chk("drained", 1, q_addr.size());
    chk("irq ack", 1, irq_ack);
    mon = 1'b0;
    @(negedge mclk);
    {bar_req, irq_req} = 2'b00;
    settle(32'h2000_0200, 2'h2, 1, 0, 0, 0, core_wdata);
    issue(32'h0000_0300, 2'h2, 1, 0, 0, 1, 0);
    wd = core_wdata;
    fork
      issue(32'h2000_0300, 2'h2, 0, 0, 0, 0, 0);
    join_none
    repeat (2) @(negedge mclk);
    chk("stall addr", 32'h0000_0300, bus_addr);
    chk("stall write", 1, bus_write);
    wait fork;
    settle(32'h0000_0300, 2'h2, 1, 0, 0, 0, wd);
    settle(32'h2000_0300, 2'h2, 0, 0, 0, 0, core_wdata);
    waits = 4'h0;
    acc(32'h2000_0204, 2'h2, 1, 0, 0, 1, 0);
    bar_req = 1'b1;
    #1;
    chk("barrier no wait", 1, bar_done);
    @(negedge mclk);
    bar_req = 1'b0;
    dbg_addr = 32'h2000_0040;
    dbg_size = 2'h2;
    fork
      begin
        @(negedge mclk);
        dbg_req = 1'b1;
      end
    join_none
    acc(32'h2000_0080, 2'h2, 0, 0, 0, 0, 0);
    wait_on(1);
    chk("dbg rdata", {pat(32'h2000_0043), pat(32'h2000_0042), pat(32'h2000_0041),
      pat(32'h2000_0040)}, dbg_rdata);
    chk("dbg fault", 0, dbg_fault);
    @(negedge mclk);
    dbg_req = 1'b0;
    chk("dbg piece", 32'h2000_0040, q_addr.pop_front());
    q_addr.delete();
    q_size.delete();
    q_wd.delete();
    q_alias.delete();
    q_tgt.delete();
    repeat (16) begin
      waits = rnd() % 4;
      acc(32'h2000_1000 + rnd() % 256, rnd() % 3, rnd() % 2, 0, 0, rnd() % 2, 0);
    end
    wrap_up();
  end
endmodule
